// >>> mdr_consts.svh
`ifndef MDR_CONSTS_SVH
`define MDR_CONSTS_SVH

// ============================================================
// Register offsets.
`define MDR_OFS_Y_LOW 8'h10
`define MDR_OFS_Y_HIGH 8'h11
`define MDR_OFS_Z_LOW 8'h12
`define MDR_OFS_Z_HIGH 8'h13
`define MDR_OFS_TEMP_LOW 8'h14
`define MDR_OFS_TEMP_HIGH 8'h15
`define MDR_OFS_RESET_KEY 8'h1f
`define MDR_OFS_MTHR_LOW 8'h20
`define MDR_OFS_MTHR_HIGH 8'h21
`define MDR_OFS_MDWELL 8'h22
`define MDR_OFS_STHR_LOW 8'h23
`define MDR_OFS_STHR_HIGH 8'h24
`define MDR_OFS_SDWELL_LOW 8'h25
`define MDR_OFS_SDWELL_HIGH 8'h26

// ============================================================
// Field positions and values.
`define MDR_SIGN_BIT 11
`define MDR_THR_HIGH_MSB 2
`define MDR_RESET_KEY_CODE 8'h52
`define MDR_KEY_READ_VALUE 8'h00
`define MDR_REG_RESET 8'h00
`define MDR_UNMAPPED_READ 8'h00

// ============================================================
// Timing.
`define MDR_CLK_PERIOD_NS 4
`define MDR_RESET_WAIT_NS 500000

`endif

// >>> mdr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module mdr_host_model (
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata,
    input wire logic reset_busy,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    // ============================================================
    // Bus cycles; released lines show the inverse of the last value.
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge core_clk);
        v = reg_rdata;
    endtask : rd
    task automatic settle(output logic ok);
        ok = 1'b0;
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 200 && !ok; i++) begin
            @(posedge core_clk);
            ok = (reset_busy === 1'b0);
        end
    endtask : settle
endmodule : mdr_host_model
`default_nettype wire

// >>> mdr_motion_regs.sv
// Overview of operation
// - Y axis result split: low byte bits 7..0, high nibble bits 11..8.
// - Top four bits of each high result register copy result bit 11.
// - Z axis result sign-extended across its low and high registers.
// - Temperature result sign-extended, high register top bits all equal.
// - Writing the key code resets every setting at once; others ignored.
// - After soft reset the interrupt pins float, held by keepers.
// - Reset-key register is write-only and reads back zero.
// - Activity compares each signed sample magnitude with 11-bit threshold.
// - Activity threshold is low byte plus three low bits of high register.
// - Activity declared after programmed run of above-threshold samples.
// - Activity dwell of zero behaves as one.
// - In wake-up mode activity needs a single above-threshold sample.
// - Inactivity compares each sample magnitude with 11-bit threshold.
// - Inactivity threshold is low byte plus three low bits of high register.
// - Inactivity declared after programmed 16-bit run of all-below samples.
// - Inactivity dwell is high register bits 15..8, low register 7..0.
// - Inactivity dwell of zero behaves as one.
// - Inactivity dwell counter reaches the full 16-bit maximum.
// - Each detector runs only while its enable bit is one.
// - An activity detection sets the activity status flag.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "mdr_consts.svh"

module mdr_motion_regs #(
    parameter int unsigned RESET_WAIT_CYCLES =
        (`MDR_RESET_WAIT_NS + `MDR_CLK_PERIOD_NS - 1) / `MDR_CLK_PERIOD_NS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic [11:0] x_sample,
    input wire logic [11:0] y_sample,
    input wire logic [11:0] z_sample,
    input wire logic temp_valid,
    input wire logic [11:0] temp_sample,
    input wire logic motion_detect_enable,
    input wire logic stillness_detect_enable,
    input wire logic wake_up_mode,
    input wire logic flag_clear,
    input wire logic int1_level,
    input wire logic int2_level,
    input wire logic int_drive_enable,
    output logic int1_out,
    output logic int1_oe,
    output logic int2_out,
    output logic int2_oe,
    output logic motion_flag,
    output logic stillness_flag,
    output logic motion_event,
    output logic stillness_event,
    output logic soft_reset_pulse,
    output logic reset_busy
);

    // ============================================================
    // Helpers.
    function automatic mdr_pkg::mdr_mag_t mdr_abs(
        input mdr_pkg::mdr_sample_t s
    );
        mdr_abs = s[`MDR_SIGN_BIT] ? mdr_pkg::mdr_mag_t'(~s + 12'h001) : s;
    endfunction : mdr_abs

    function automatic logic [7:0] mdr_sx_high(
        input mdr_pkg::mdr_sample_t s
    );
        mdr_sx_high = {{4{s[`MDR_SIGN_BIT]}}, s[11:8]};
    endfunction : mdr_sx_high

    // ============================================================
    // Soft reset decode.
    logic soft_hit;
    logic wr_any;

    assign wr_any = reg_wr;
    assign soft_hit = reg_wr && (reg_addr == `MDR_OFS_RESET_KEY) &&
        (reg_wdata == `MDR_RESET_KEY_CODE);

    // ============================================================
    // Result registers.
    mdr_pkg::mdr_sample_t y_q;
    mdr_pkg::mdr_sample_t z_q;
    mdr_pkg::mdr_sample_t temp_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            y_q <= 12'h000;
            z_q <= 12'h000;
        end else if (soft_hit) begin
            y_q <= 12'h000;
            z_q <= 12'h000;
        end else if (sample_valid) begin
            y_q <= y_sample;
            z_q <= z_sample;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            temp_q <= 12'h000;
        end else if (soft_hit) begin
            temp_q <= 12'h000;
        end else if (temp_valid) begin
            temp_q <= temp_sample;
        end
    end

    // ============================================================
    // Configuration registers.
    logic [7:0] mthr_low_q;
    logic [2:0] mthr_high_q;
    logic [7:0] mdwell_q;
    logic [7:0] sthr_low_q;
    logic [2:0] sthr_high_q;
    logic [7:0] sdwell_low_q;
    logic [7:0] sdwell_high_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mthr_low_q <= `MDR_REG_RESET;
            mthr_high_q <= 3'h0;
            mdwell_q <= `MDR_REG_RESET;
            sthr_low_q <= `MDR_REG_RESET;
            sthr_high_q <= 3'h0;
            sdwell_low_q <= `MDR_REG_RESET;
            sdwell_high_q <= `MDR_REG_RESET;
        end else if (soft_hit) begin
            mthr_low_q <= `MDR_REG_RESET;
            mthr_high_q <= 3'h0;
            mdwell_q <= `MDR_REG_RESET;
            sthr_low_q <= `MDR_REG_RESET;
            sthr_high_q <= 3'h0;
            sdwell_low_q <= `MDR_REG_RESET;
            sdwell_high_q <= `MDR_REG_RESET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `MDR_OFS_MTHR_LOW: mthr_low_q <= reg_wdata;
                `MDR_OFS_MTHR_HIGH: begin
                    mthr_high_q <= reg_wdata[`MDR_THR_HIGH_MSB:0];
                end
                `MDR_OFS_MDWELL: mdwell_q <= reg_wdata;
                `MDR_OFS_STHR_LOW: sthr_low_q <= reg_wdata;
                `MDR_OFS_STHR_HIGH: begin
                    sthr_high_q <= reg_wdata[`MDR_THR_HIGH_MSB:0];
                end
                `MDR_OFS_SDWELL_LOW: sdwell_low_q <= reg_wdata;
                `MDR_OFS_SDWELL_HIGH: sdwell_high_q <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    mdr_pkg::mdr_thr_t motion_threshold;
    mdr_pkg::mdr_thr_t stillness_threshold;
    mdr_pkg::mdr_dwell_t stillness_dwell;

    assign motion_threshold = {mthr_high_q, mthr_low_q};
    assign stillness_threshold = {sthr_high_q, sthr_low_q};
    assign stillness_dwell = {sdwell_high_q, sdwell_low_q};

    // ============================================================
    // Per-axis threshold comparison.
    mdr_pkg::mdr_sample_t axis [3];
    logic [2:0] above;
    logic [2:0] below;

    assign axis[0] = x_sample;
    assign axis[1] = y_sample;
    assign axis[2] = z_sample;

    for (genvar i = 0; i < 3; i++) begin : g_axis
        mdr_pkg::mdr_mag_t mag;
        assign mag = mdr_abs(axis[i]);
        assign above[i] = mag > {1'b0, motion_threshold};
        assign below[i] = mag < {1'b0, stillness_threshold};
    end

    // ============================================================
    // Activity dwell counter.
    logic [7:0] mcnt_q;
    logic [7:0] mtarget;
    logic motion_hit;

    always_comb begin
        if (wake_up_mode) begin
            mtarget = 8'h01;
        end else if (mdwell_q == 8'h00) begin
            mtarget = 8'h01;
        end else begin
            mtarget = mdwell_q;
        end
    end

    assign motion_hit = sample_valid && motion_detect_enable &&
        (|above) && (mcnt_q < mtarget) &&
        ((mcnt_q + 8'h01) == mtarget);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mcnt_q <= 8'h00;
        end else if (soft_hit || !motion_detect_enable) begin
            mcnt_q <= 8'h00;
        end else if (sample_valid) begin
            if (!(|above)) begin
                mcnt_q <= 8'h00;
            end else if (mcnt_q < mtarget) begin
                mcnt_q <= mcnt_q + 8'h01;
            end
        end
    end

    // ============================================================
    // Inactivity dwell counter.
    mdr_pkg::mdr_dwell_t scnt_q;
    mdr_pkg::mdr_dwell_t starget;
    logic still_hit;

    assign starget = (stillness_dwell == 16'h0000) ? 16'h0001 :
        stillness_dwell;

    assign still_hit = sample_valid && stillness_detect_enable &&
        (&below) && (scnt_q < starget) &&
        ((scnt_q + 16'h0001) == starget);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scnt_q <= 16'h0000;
        end else if (soft_hit || !stillness_detect_enable) begin
            scnt_q <= 16'h0000;
        end else if (sample_valid) begin
            if (!(&below)) begin
                scnt_q <= 16'h0000;
            end else if (scnt_q < starget) begin
                scnt_q <= scnt_q + 16'h0001;
            end
        end
    end

    // ============================================================
    // Events and sticky flags.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            motion_event <= 1'b0;
            stillness_event <= 1'b0;
        end else begin
            motion_event <= motion_hit && !soft_hit;
            stillness_event <= still_hit && !soft_hit;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            motion_flag <= 1'b0;
            stillness_flag <= 1'b0;
        end else if (soft_hit) begin
            motion_flag <= 1'b0;
            stillness_flag <= 1'b0;
        end else begin
            motion_flag <= motion_hit || (motion_flag && !flag_clear);
            stillness_flag <= still_hit || (stillness_flag && !flag_clear);
        end
    end

    // ============================================================
    // Interrupt pin release and reset recovery.
    logic float_q;
    logic [16:0] wait_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            float_q <= 1'b1;
        end else if (soft_hit) begin
            float_q <= 1'b1;
        end else if (wr_any) begin
            float_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            int1_out <= 1'b0;
            int2_out <= 1'b0;
            int1_oe <= 1'b0;
            int2_oe <= 1'b0;
        end else begin
            int1_out <= int1_level;
            int2_out <= int2_level;
            int1_oe <= int_drive_enable && !float_q && !soft_hit;
            int2_oe <= int_drive_enable && !float_q && !soft_hit;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= soft_hit;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 17'h00000;
        end else if (soft_hit) begin
            wait_q <= 17'(RESET_WAIT_CYCLES);
        end else if (wait_q != 17'h00000) begin
            wait_q <= wait_q - 17'h00001;
        end
    end

    assign reset_busy = wait_q != 17'h00000;

    // ============================================================
    // Read port.
    logic [7:0] rd_d;

    always_comb begin
        unique case (reg_addr)
            `MDR_OFS_Y_LOW: rd_d = y_q[7:0];
            `MDR_OFS_Y_HIGH: rd_d = mdr_sx_high(y_q);
            `MDR_OFS_Z_LOW: rd_d = z_q[7:0];
            `MDR_OFS_Z_HIGH: rd_d = mdr_sx_high(z_q);
            `MDR_OFS_TEMP_LOW: rd_d = temp_q[7:0];
            `MDR_OFS_TEMP_HIGH: rd_d = mdr_sx_high(temp_q);
            `MDR_OFS_RESET_KEY: rd_d = `MDR_KEY_READ_VALUE;
            `MDR_OFS_MTHR_LOW: rd_d = mthr_low_q;
            `MDR_OFS_MTHR_HIGH: rd_d = {5'h00, mthr_high_q};
            `MDR_OFS_MDWELL: rd_d = mdwell_q;
            `MDR_OFS_STHR_LOW: rd_d = sthr_low_q;
            `MDR_OFS_STHR_HIGH: rd_d = {5'h00, sthr_high_q};
            `MDR_OFS_SDWELL_LOW: rd_d = sdwell_low_q;
            `MDR_OFS_SDWELL_HIGH: rd_d = sdwell_high_q;
            default: rd_d = `MDR_UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : mdr_motion_regs

`default_nettype wire

// >>> mdr_motion_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module mdr_motion_regs_bench;
    logic core_clk, rst_n, reg_wr, reg_rd, sample_valid, temp_valid;
    logic motion_detect_enable, stillness_detect_enable, wake_up_mode;
    logic flag_clear, int_drive_enable, int1_oe, int2_oe, int1_out;
    logic int2_out, motion_flag, stillness_flag, motion_event, ok;
    logic stillness_event, soft_reset_pulse, reset_busy;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    mdr_pkg::mdr_sample_t x_sample, y_sample, z_sample, temp_sample;
    int num_errors, n_tests, mcnt, scnt, n;
    // ============================================================
    // Clock, design, host, event counters and scenarios.
    always #2 core_clk = ~core_clk;
    mdr_motion_regs #(.RESET_WAIT_CYCLES(20)) dut (.core_clk, .rst_n,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .sample_valid, .x_sample, .y_sample, .z_sample, .temp_valid,
        .temp_sample, .motion_detect_enable, .stillness_detect_enable,
        .wake_up_mode, .flag_clear, .int1_level(1'b1),
        .int2_level(1'b0), .int_drive_enable, .int1_out, .int1_oe,
        .int2_out, .int2_oe, .motion_flag, .stillness_flag,
        .motion_event, .stillness_event, .soft_reset_pulse, .reset_busy);
    mdr_host_model h (.core_clk, .reg_rdata, .reset_busy, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd);
    always @(posedge core_clk) begin
        if (motion_event === 1'b1) mcnt <= mcnt + 1;
        if (stillness_event === 1'b1) scnt <= scnt + 1;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        h.rd(a, d);
        chk({8'h00, d}, {8'h00, e});
    endtask : rchk
    task automatic smp(input mdr_pkg::mdr_sample_t x, y, z);
        @(posedge core_clk);
        {sample_valid, temp_valid} <= 2'b11;
        {x_sample, y_sample, z_sample} <= {x, y, z};
        @(posedge core_clk);
        {sample_valid, temp_valid} <= 2'b00;
        {x_sample, y_sample, z_sample} <= ~{x, y, z};
        @(posedge core_clk);
        @(negedge core_clk);
    endtask : smp
    task automatic t_regs;
        for (int a = 'h10; a < 'h27; a++) rchk(8'(a), 8'h00);
        h.wr(8'h21, 8'hff);
        rchk(8'h21, 8'h07);
        h.wr(8'h24, 8'hff);
        rchk(8'h24, 8'h07);
        h.wr(8'h10, 8'h55);
        rchk(8'h10, 8'h00);
        h.wr(8'h22, 8'h33);
        h.wr(8'h1f, 8'h51);
        rchk(8'h22, 8'h33);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_data;
        temp_sample <= 12'hc3a;
        smp(12'h000, 12'h8a5, 12'h17f);
        rchk(8'h10, 8'ha5);
        rchk(8'h11, 8'hf8);
        rchk(8'h12, 8'h7f);
        rchk(8'h13, 8'h01);
        rchk(8'h14, 8'h3a);
        rchk(8'h15, 8'hfc);
        $display("t_data done");
    endtask : t_data
    task automatic t_motion;
        h.wr(8'h20, 8'h05);
        h.wr(8'h21, 8'h01);
        h.wr(8'h22, 8'h03);
        motion_detect_enable <= 1'b1;
        n = mcnt;
        smp(12'h106, 12'h000, 12'h000);
        smp(12'hefa, 12'h000, 12'h000);
        smp(12'h105, 12'h000, 12'h000);
        smp(12'h000, 12'h106, 12'h000);
        smp(12'h000, 12'h000, 12'hefa);
        chk(16'(mcnt - n), 16'h0000);
        smp(12'h800, 12'h000, 12'h000);
        chk(16'(mcnt - n), 16'h0001);
        chk(motion_flag, 1'b1);
        h.wr(8'h22, 8'h00);
        smp(12'h000, 12'h000, 12'h000);
        smp(12'h106, 12'h000, 12'h000);
        chk(16'(mcnt - n), 16'h0002);
        h.wr(8'h22, 8'h03);
        wake_up_mode <= 1'b1;
        smp(12'h000, 12'h000, 12'h000);
        smp(12'h106, 12'h000, 12'h000);
        chk(16'(mcnt - n), 16'h0003);
        @(posedge core_clk);
        motion_detect_enable <= 1'b0;
        smp(12'h000, 12'h000, 12'h000);
        smp(12'h106, 12'h000, 12'h000);
        chk(16'(mcnt - n), 16'h0003);
        @(posedge core_clk);
        flag_clear <= 1'b1;
        @(posedge core_clk);
        flag_clear <= 1'b0;
        @(negedge core_clk);
        chk(motion_flag, 1'b0);
        $display("t_motion done");
    endtask : t_motion
    task automatic t_still;
        h.wr(8'h23, 8'h10);
        h.wr(8'h24, 8'h00);
        h.wr(8'h25, 8'h02);
        h.wr(8'h26, 8'h01);
        stillness_detect_enable <= 1'b1;
        n = scnt;
        smp(12'h010, 12'h000, 12'h000);
        for (int i = 0; i < 257; i++) smp(12'hff1, 12'h00f, 12'h000);
        chk(16'(scnt - n), 16'h0000);
        smp(12'h000, 12'h000, 12'h000);
        chk(16'(scnt - n), 16'h0001);
        chk(stillness_flag, 1'b1);
        h.wr(8'h26, 8'h00);
        h.wr(8'h25, 8'h00);
        smp(12'h000, 12'hff0, 12'h000);
        smp(12'h000, 12'h000, 12'h000);
        chk(16'(scnt - n), 16'h0002);
        $display("t_still done");
    endtask : t_still
    task automatic t_reset;
        h.wr(8'h20, 8'h7b);
        h.wr(8'h1f, 8'h52);
        @(negedge core_clk);
        chk(soft_reset_pulse, 1'b1);
        chk({int1_oe, int2_oe}, 2'b00);
        chk(reset_busy, 1'b1);
        h.settle(ok);
        chk(ok, 1'b1);
        rchk(8'h20, 8'h00);
        chk({int1_oe, int2_oe}, 2'b00);
        h.wr(8'h20, 8'h00);
        repeat (2) @(negedge core_clk);
        chk({int1_oe, int2_oe, int1_out, int2_out}, 4'he);
        $display("t_reset done");
    endtask : t_reset
    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    initial begin
        {core_clk, rst_n, sample_valid, temp_valid, flag_clear} = '0;
        {motion_detect_enable, stillness_detect_enable} = 2'b00;
        {wake_up_mode, int_drive_enable} = 2'b01;
        {x_sample, y_sample, z_sample, temp_sample} = '0;
        {num_errors, n_tests, mcnt, scnt, n} = '0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs;
        t_data;
        t_motion;
        t_still;
        t_reset;
        give_verdict;
    end
endmodule : mdr_motion_regs_bench
`default_nettype wire

// >>> mdr_motion_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module mdr_motion_regs_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic motion_detect_enable,
    input wire logic int1_oe,
    input wire logic int2_oe,
    input wire logic motion_flag,
    input wire logic motion_event,
    input wire logic soft_reset_pulse
);
    // ============================================================
    // Register bus, soft reset and activity checks.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence rd_at(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence key_wr(logic [7:0] v);
        reg_wr && reg_addr == 8'h1f && reg_wdata == v;
    endsequence
    property sx_ok(logic [7:0] a);
        rd_at(a) |=> reg_rdata[7:4] == {4{reg_rdata[3]}};
    endproperty
    a_key_zero:
        assert property (rd_at(8'h1f) |=> reg_rdata == 8'h00)
        else $error("key register read not zero");
    a_y_sign:
        assert property (sx_ok(8'h11)) else $error("y sign copies wrong");
    a_z_sign:
        assert property (sx_ok(8'h13)) else $error("z sign copies wrong");
    a_temp_sign:
        assert property (sx_ok(8'h15)) else $error("temp sign copies wrong");
    a_key_pulse:
        assert property (key_wr(8'h52) |=> soft_reset_pulse)
        else $error("key write gave no reset");
    a_pins_float:
        assert property (key_wr(8'h52) |=> !int1_oe && !int2_oe)
        else $error("pins driven after reset");
    a_flag_follows:
        assert property (motion_event |-> motion_flag)
        else $error("event without flag");
    a_event_single:
        assert property (motion_event |=> !motion_event)
        else $error("event repeated");
    a_off_quiet:
        assert property (!motion_detect_enable |=> !motion_event)
        else $error("event while disabled");
endmodule : mdr_motion_regs_properties
bind mdr_motion_regs mdr_motion_regs_properties chk (.core_clk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .motion_detect_enable, .int1_oe, .int2_oe, .motion_flag,
    .motion_event, .soft_reset_pulse);
`default_nettype wire

// >>> mdr_pkg.sv
package mdr_pkg;

    typedef logic [11:0] mdr_sample_t;
    typedef logic [11:0] mdr_mag_t;
    typedef logic [10:0] mdr_thr_t;
    typedef logic [15:0] mdr_dwell_t;

endpackage : mdr_pkg
